// >>> include/tba_regs.vh
// Constants for the tag block access packet framer.
// Assumes inclusion by bare name from the rtl sources; no process lives here.
`ifndef TBA_REGS_VH
`define TBA_REGS_VH

// Envelope bytes
`define TBA_HDR_BYTE      8'h01
`define TBA_PASS_CMD      8'h60
`define TBA_RSP_OK_FLAGS  8'h00
`define TBA_RFLAG_ERR_BIT 4

// Request byte positions within the envelope
`define TBA_POS_LEN_LO    16'h0001
`define TBA_POS_LEN_HI    16'h0002
`define TBA_POS_CMD       16'h0006
`define TBA_POS_BODY      16'h0008
`define TBA_REQ_OVERHEAD  16'h000A
`define TBA_REQ_MIN_LEN   16'h000C

// Response layout
`define TBA_RSP_OVERHEAD  16'h0009
`define TBA_RSP_DATA_POS  16'h0007

// Tag command codes
`define TBA_CODE_RD_ONE   8'h20
`define TBA_CODE_WR_ONE   8'h21
`define TBA_CODE_LOCK     8'h22
`define TBA_CODE_RD_MANY  8'h23
`define TBA_CODE_WR_FAM   8'h27

// Tag flag fields
`define TBA_TAG_ERR_BIT   0
`define TBA_TAG_RFU_BIT   7

// Reader error codes
`define TBA_ERR_NO_TAG    8'h01
`define TBA_ERR_UNSUP     8'h02
`define TBA_ERR_FLAGS     8'h04

// Tag reply wait: time in microseconds and derived cycles at 10 MHz
`define TBA_CLK_MHZ       16'h000A
`define TBA_TAG_WAIT_US   16'h1388
`define TBA_TAG_WAIT_CYC  (`TBA_TAG_WAIT_US * `TBA_CLK_MHZ)

`endif

// >>> rtl/tba_xor_sum.v
// Running XOR checksum over envelope bytes.
// Assumes the caller decides which bytes belong to the sum.
module tba_xor_sum (
   // Clock and reset
   input wire ref_clk,
   input wire rst_b,
   // Control
   input wire clr,
   input wire en,
   input wire [7:0] din,
   // Result
   output reg [7:0] sum
);

   // Clear and accumulate in one cycle seeds the sum with the first byte
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sum <= 8'h00;
      end else if (clr) begin
         sum <= en ? din : 8'h00;
      end else if (en) begin
         sum <= sum ^ din;
      end
   end

endmodule

// >>> rtl/tba_framer.v
// Reader-side framer for pass-through tag block commands.
// Assumes byte streams synchronous to ref_clk; the tag side delivers reply bytes ending in its CRC16.
`include "tba_regs.vh"

// Contract
// - Requests arrive as 01, length, node address, flag, 60, config, tag bytes, checksum.
// - Responses leave as 01, length, node address, flags, 60, tag data, checksum.
// - No SOF, CRC16 or EOF in packets; tag CRC is stripped from replies.
// - Read single block code 20 is forwarded and its reply returned.
// - Failed tag reply returns exactly flags byte and error code byte.
// - Successful single read returns flags, security status, then block data.
// - Write or lock returns flags alone on success, flags plus code on failure.
// - Lock block code 22 uses the same pass-through envelope.
// - Successful multiple read returns flags, security status, then block data.
// - Checksum one is XOR of header through data; checksum two is FF XOR one.
// - Response flags bit 4 marks an error; other bits are zero.
// - Reader errors: 01 no transponder, 02 unsupported command, 04 invalid flags.
module tba_framer #(
   parameter BUF_DEPTH = 64,
   parameter IW = 6,
   parameter [15:0] TAG_WAIT_CYC = `TBA_TAG_WAIT_CYC
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst_b,
   // Reader identity
   input wire [15:0] node_addr,
   // Host request bytes
   input wire host_rx_valid,
   input wire [7:0] host_rx_data,
   // Host response bytes
   output reg host_tx_valid,
   output reg [7:0] host_tx_data,
   input wire host_tx_ready,
   // Tag command bytes
   output reg tag_tx_valid,
   output reg [7:0] tag_tx_data,
   output reg tag_tx_last,
   input wire tag_tx_ready,
   // Tag reply bytes
   input wire tag_rx_valid,
   input wire [7:0] tag_rx_data,
   input wire tag_rx_last,
   // Status
   output reg busy,
   output reg frame_drop
);

   localparam [2:0] ST_RX = 3'h0;
   localparam [2:0] ST_CHK = 3'h1;
   localparam [2:0] ST_FWD = 3'h2;
   localparam [2:0] ST_WAIT = 3'h3;
   localparam [2:0] ST_SEND = 3'h4;
   // Depth cut to the 16-bit counter width on purpose
   localparam [31:0] DEPTH32 = BUF_DEPTH;
   localparam [15:0] DEPTH16 = DEPTH32[15:0];

   // Supported block command decode
   function supported;
      input [7:0] code;
      begin
         supported = (code == `TBA_CODE_RD_ONE) || (code == `TBA_CODE_WR_ONE) ||
                     (code == `TBA_CODE_LOCK) || (code == `TBA_CODE_RD_MANY) ||
                     (code == `TBA_CODE_WR_FAM);
      end
   endfunction

   reg [2:0] state;
   reg [7:0] mem [0:BUF_DEPTH-1];
   reg [15:0] pos;
   reg [7:0] len_lo;
   reg [15:0] req_len;
   reg bad;
   reg [15:0] ptr;
   reg [15:0] rcnt;
   reg [15:0] timer;
   reg [15:0] rsp_len;
   reg [15:0] sp;
   reg rd_err;
   reg [7:0] err_code;
   reg ck_clr;
   reg ck_en;
   reg [7:0] ck_din;
   reg [7:0] rsp_byte;
   wire [7:0] sum;
   wire [15:0] body_idx = pos - `TBA_POS_BODY;
   wire [15:0] data_idx = sp - `TBA_RSP_DATA_POS;
   wire [15:0] req_n = req_len - `TBA_REQ_OVERHEAD;
   wire [15:0] reply_total = rcnt + 16'h0001;
   wire rx_take = (state == ST_RX) && host_rx_valid;
   wire rx_started = (pos != 16'h0000);
   wire rx_end = (pos >= 16'h0003) && (pos + 16'h0001 >= req_len);
   wire tx_load = !host_tx_valid || host_tx_ready;

   ////////////////////////////////////////////////////////////////////////////////
   // Checksum steering, shared by request check and response build
   always @* begin
      ck_clr = 1'b0;
      ck_en = 1'b0;
      ck_din = host_rx_data;
      if (rx_take && !rx_started) begin
         ck_clr = 1'b1;
         ck_en = (host_rx_data == `TBA_HDR_BYTE);
      end else if (rx_take) begin
         ck_en = (pos < 16'h0003) || (pos + 16'h0002 < req_len);
      end else if (state == ST_SEND && tx_load && sp < rsp_len) begin
         ck_clr = (sp == 16'h0000);
         ck_en = (sp + 16'h0002 < rsp_len);
         ck_din = rsp_byte;
      end
   end

   tba_xor_sum u_sum (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clr(ck_clr),
      .en(ck_en),
      .din(ck_din),
      .sum(sum)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Response byte selection by position
   always @* begin
      if (sp == 16'h0000) begin
         rsp_byte = `TBA_HDR_BYTE;
      end else if (sp == 16'h0001) begin
         rsp_byte = rsp_len[7:0];
      end else if (sp == 16'h0002) begin
         rsp_byte = rsp_len[15:8];
      end else if (sp == 16'h0003) begin
         rsp_byte = node_addr[7:0];
      end else if (sp == 16'h0004) begin
         rsp_byte = node_addr[15:8];
      end else if (sp == 16'h0005) begin
         rsp_byte = rd_err ? (8'h01 << `TBA_RFLAG_ERR_BIT) : `TBA_RSP_OK_FLAGS;
      end else if (sp == 16'h0006) begin
         rsp_byte = `TBA_PASS_CMD;
      end else if (sp + 16'h0002 == rsp_len) begin
         rsp_byte = sum;
      end else if (sp + 16'h0001 == rsp_len) begin
         rsp_byte = ~sum;
      end else begin
         rsp_byte = rd_err ? err_code : mem[data_idx[IW-1:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Buffer writes: request body first, then the tag reply in the same space
   always @(posedge ref_clk) begin
      if (rx_take && rx_started && pos >= `TBA_POS_BODY && body_idx < DEPTH16) begin
         mem[body_idx[IW-1:0]] <= host_rx_data;
      end else if (state == ST_WAIT && tag_rx_valid && rcnt < DEPTH16) begin
         mem[rcnt[IW-1:0]] <= tag_rx_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Exchange sequencer
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_RX;
         pos <= 16'h0000;
         len_lo <= 8'h00;
         req_len <= 16'h0000;
         bad <= 1'b0;
         ptr <= 16'h0000;
         rcnt <= 16'h0000;
         timer <= 16'h0000;
         rsp_len <= 16'h0000;
         sp <= 16'h0000;
         rd_err <= 1'b0;
         err_code <= 8'h00;
         host_tx_valid <= 1'b0;
         host_tx_data <= 8'h00;
         tag_tx_valid <= 1'b0;
         tag_tx_data <= 8'h00;
         tag_tx_last <= 1'b0;
         busy <= 1'b0;
         frame_drop <= 1'b0;
      end else begin
         frame_drop <= 1'b0;
         case (state)
            ST_RX: begin
               // Bytes arriving outside this state are ignored; host waits for the answer
               if (host_rx_valid) begin
                  if (!rx_started) begin
                     bad <= 1'b0;
                     req_len <= 16'hFFFF;
                     if (host_rx_data == `TBA_HDR_BYTE) begin
                        pos <= 16'h0001;
                     end
                  end else begin
                     pos <= pos + 16'h0001;
                     if (pos == `TBA_POS_LEN_LO) begin
                        len_lo <= host_rx_data;
                     end else if (pos == `TBA_POS_LEN_HI) begin
                        req_len <= {host_rx_data, len_lo};
                        if ({host_rx_data, len_lo} < `TBA_REQ_MIN_LEN ||
                            {host_rx_data, len_lo} - `TBA_REQ_OVERHEAD > DEPTH16) begin
                           bad <= 1'b1;
                        end
                     end else if (pos == `TBA_POS_CMD && host_rx_data != `TBA_PASS_CMD) begin
                        bad <= 1'b1;
                     end else if (pos + 16'h0002 == req_len && host_rx_data != sum) begin
                        bad <= 1'b1;
                     end
                     if (rx_end) begin
                        pos <= 16'h0000;
                        // Second checksum byte checked here; sum is frozen across both
                        if (bad || host_rx_data != ~sum || pos < 16'h0003) begin
                           frame_drop <= 1'b1;
                        end else begin
                           state <= ST_CHK;
                           busy <= 1'b1;
                        end
                     end
                  end
               end
            end
            ST_CHK: begin
               // Command check before flags check; the tag never sees a rejected request
               if (!supported(mem[1])) begin
                  rd_err <= 1'b1;
                  err_code <= `TBA_ERR_UNSUP;
                  rsp_len <= `TBA_RSP_OVERHEAD + 16'h0001;
                  sp <= 16'h0000;
                  state <= ST_SEND;
               end else if (mem[0][`TBA_TAG_RFU_BIT]) begin
                  rd_err <= 1'b1;
                  err_code <= `TBA_ERR_FLAGS;
                  rsp_len <= `TBA_RSP_OVERHEAD + 16'h0001;
                  sp <= 16'h0000;
                  state <= ST_SEND;
               end else begin
                  rd_err <= 1'b0;
                  ptr <= 16'h0000;
                  state <= ST_FWD;
               end
            end
            ST_FWD: begin
               if (!tag_tx_valid || tag_tx_ready) begin
                  if (ptr < req_n) begin
                     tag_tx_valid <= 1'b1;
                     tag_tx_data <= mem[ptr[IW-1:0]];
                     tag_tx_last <= (ptr + 16'h0001 == req_n);
                     ptr <= ptr + 16'h0001;
                  end else begin
                     tag_tx_valid <= 1'b0;
                     tag_tx_last <= 1'b0;
                     rcnt <= 16'h0000;
                     timer <= 16'h0000;
                     state <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               timer <= timer + 16'h0001;
               if (tag_rx_valid) begin
                  rcnt <= rcnt + 16'h0001;
               end
               sp <= 16'h0000;
               if (tag_rx_valid && tag_rx_last) begin
                  // Drop the trailing CRC16; short replies count as no transponder
                  if (reply_total < 16'h0003) begin
                     rd_err <= 1'b1;
                     err_code <= `TBA_ERR_NO_TAG;
                     rsp_len <= `TBA_RSP_OVERHEAD + 16'h0001;
                  end else if (mem[0][`TBA_TAG_ERR_BIT]) begin
                     rsp_len <= `TBA_RSP_OVERHEAD + 16'h0002;
                  end else if (reply_total - 16'h0002 > DEPTH16) begin
                     rsp_len <= `TBA_RSP_OVERHEAD + DEPTH16;
                  end else begin
                     rsp_len <= `TBA_RSP_OVERHEAD + reply_total - 16'h0002;
                  end
                  state <= ST_SEND;
               end else if (timer + 16'h0001 >= TAG_WAIT_CYC) begin
                  rd_err <= 1'b1;
                  err_code <= `TBA_ERR_NO_TAG;
                  rsp_len <= `TBA_RSP_OVERHEAD + 16'h0001;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (tx_load) begin
                  if (sp < rsp_len) begin
                     host_tx_valid <= 1'b1;
                     host_tx_data <= rsp_byte;
                     sp <= sp + 16'h0001;
                  end else begin
                     host_tx_valid <= 1'b0;
                     busy <= 1'b0;
                     rd_err <= 1'b0;
                     state <= ST_RX;
                  end
               end
            end
            default: begin
               state <= ST_RX;
            end
         endcase
      end
   end

endmodule

// >>> tb/tba_framer_monitor.sv
// Port checker for the tag block access framer.
// Assumes binding into tba_framer; one ref_clk domain, rst_b active low.
module tba_framer_monitor (
   // Clock and reset
   input wire ref_clk,
   input wire rst_b,
   // Watched ports
   input wire host_tx_valid,
   input wire [7:0] host_tx_data,
   input wire host_tx_ready,
   input wire tag_tx_valid,
   input wire [7:0] tag_tx_data,
   input wire tag_tx_last,
   input wire tag_tx_ready,
   input wire busy,
   input wire frame_drop
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   //////////////////////////////////////////
   // Handshakes must hold until taken
   a_rsp_byte_held: assert property (host_tx_valid && !host_tx_ready |=>
      host_tx_valid && $stable(host_tx_data))
      else $error("response byte changed before taken");
   a_cmd_byte_held: assert property (tag_tx_valid && !tag_tx_ready |=>
      tag_tx_valid && $stable({tag_tx_data, tag_tx_last}))
      else $error("tag byte changed before taken");
   a_last_with_valid: assert property (tag_tx_last |-> tag_tx_valid)
      else $error("last marker without valid");
   // Traffic only inside an exchange, never both ways at once
   a_rsp_in_busy: assert property (host_tx_valid |-> busy)
      else $error("response byte outside busy");
   a_cmd_in_busy: assert property (tag_tx_valid |-> busy)
      else $error("tag byte outside busy");
   a_no_overlap: assert property (tag_tx_valid |-> !host_tx_valid)
      else $error("response overlaps tag command");
   // Dropped frames leave no trace
   a_drop_pulse: assert property (frame_drop |=> !frame_drop)
      else $error("drop pulse too long");
   a_drop_no_fwd: assert property (frame_drop |-> !tag_tx_valid [*8])
      else $error("dropped frame forwarded");
   a_drop_idle: assert property (frame_drop |-> !busy ##1 !busy)
      else $error("dropped frame made block busy");
endmodule

bind tba_framer tba_framer_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b), .host_tx_valid(host_tx_valid),
   .host_tx_data(host_tx_data), .host_tx_ready(host_tx_ready), .tag_tx_valid(tag_tx_valid),
   .tag_tx_data(tag_tx_data), .tag_tx_last(tag_tx_last), .tag_tx_ready(tag_tx_ready), .busy(busy),
   .frame_drop(frame_drop));

// >>> tb/tba_tag_model.sv
// Behavioural tag: takes command bytes, replies flags, data and a CRC pair.
// Assumes the bench sets slow, mute, fail and n_rep between exchanges.
module tba_tag_model (
   // Clock and reset
   input wire ref_clk,
   input wire rst_b,
   // Command bytes
   input wire tag_tx_valid,
   input wire [7:0] tag_tx_data,
   input wire tag_tx_last,
   output logic tag_tx_ready,
   // Reply bytes
   output logic tag_rx_valid = 1'b0,
   output logic [7:0] tag_rx_data = 8'h00,
   output logic tag_rx_last = 1'b0,
   // Behaviour knobs
   input wire slow,
   input wire mute,
   input wire fail,
   input wire [7:0] n_rep
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cmd_q[$];
   // Slow mode stalls every other cycle
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         tag_tx_ready <= 1'b0;
      else
         tag_tx_ready <= slow ? ~tag_tx_ready : 1'b1;
   end
   // Reply after the last command byte; mute leaves the reader to time out
   always @(posedge ref_clk) begin
      if (tag_tx_valid && tag_tx_ready) begin
         cmd_q.push_back(tag_tx_data);
         if (tag_tx_last && !mute) begin
            repeat (slow ? 30 : 3) @(posedge ref_clk);
            for (int i = 0; i < n_rep + 3; i++) begin
               tag_rx_valid <= 1'b1;
               tag_rx_data <= (i == 0) ? {7'h00, fail} : (i <= n_rep) ? 8'hAF + 8'(i) : 8'hC3;
               tag_rx_last <= (i == n_rep + 2);
               @(posedge ref_clk);
            end
            // Released data shows the inverse, never a stale byte
            tag_rx_valid <= 1'b0;
            tag_rx_last <= 1'b0;
            tag_rx_data <= ~tag_rx_data;
         end
      end
   end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for tba_framer with a behavioural tag.
// Assumes a 10 MHz ref_clk and a shortened tag reply wait of 50 cycles.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [7:0] tba_q8[$];
   `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); end end
   logic ref_clk = 1'b0, rst_b = 1'b0, host_rx_valid = 1'b0, host_tx_ready = 1'b1;
   logic slow = 1'b0, mute = 1'b0, fail = 1'b0;
   logic [7:0] host_rx_data = 8'h00, n_rep = 8'h00;
   logic [15:0] node_addr = 16'hBEEF;
   wire host_tx_valid, tag_tx_valid, tag_tx_last, tag_tx_ready, tag_rx_valid, tag_rx_last, busy, frame_drop;
   wire [7:0] host_tx_data, tag_tx_data, tag_rx_data;
   int miscompares = 0, n_tests = 0;
   tba_framer #(.TAG_WAIT_CYC(16'd50)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .node_addr(node_addr),
      .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data), .host_tx_valid(host_tx_valid),
      .host_tx_data(host_tx_data), .host_tx_ready(host_tx_ready), .tag_tx_valid(tag_tx_valid),
      .tag_tx_data(tag_tx_data), .tag_tx_last(tag_tx_last), .tag_tx_ready(tag_tx_ready),
      .tag_rx_valid(tag_rx_valid), .tag_rx_data(tag_rx_data), .tag_rx_last(tag_rx_last), .busy(busy),
      .frame_drop(frame_drop));
   tba_tag_model tag (.ref_clk(ref_clk), .rst_b(rst_b), .tag_tx_valid(tag_tx_valid), .tag_tx_data(tag_tx_data),
      .tag_tx_last(tag_tx_last), .tag_tx_ready(tag_tx_ready), .tag_rx_valid(tag_rx_valid),
      .tag_rx_data(tag_rx_data), .tag_rx_last(tag_rx_last), .slow(slow), .mute(mute), .fail(fail), .n_rep(n_rep));
   //////////////////////////////////////////
   // Tag body: flags, code, identifier 11..18, then n extra bytes
   function automatic tba_q8 mk(input logic [7:0] fl, input logic [7:0] cd, input int n);
      tba_q8 r;
      r = {fl, cd};
      for (int i = 0; i < 8 + n; i++)
         r.push_back(i < 8 ? 8'h11 + 8'(i) : 8'h40 + 8'(i));
      return r;
   endfunction
   // Host request in the pass-through envelope; bad spoils the second checksum byte
   task automatic send(input tba_q8 b, input logic bad);
      logic [7:0] f[$];
      logic [7:0] ck;
      f = {8'h01, 8'(b.size() + 10), 8'h00, 8'h34, 8'h12, 8'h00, 8'h60, 8'h00, b};
      ck = 8'h00;
      foreach (f[i]) ck ^= f[i];
      f = {f, ck, ck ^ 8'hFF ^ {7'h00, bad}};
      tag.cmd_q.delete();
      foreach (f[i]) begin
         @(posedge ref_clk);
         host_rx_valid <= 1'b1;
         host_rx_data <= f[i];
      end
      @(posedge ref_clk);
      host_rx_valid <= 1'b0;
      host_rx_data <= ~host_rx_data;
   endtask
   // Collect the response, optionally stalling the host side
   task automatic expect_rsp(input logic [7:0] rf, input tba_q8 d, input logic stall);
      logic [7:0] e[$];
      logic [7:0] ck;
      int k;
      e = {8'h01, 8'(d.size() + 9), 8'h00, node_addr[7:0], node_addr[15:8], rf, 8'h60, d};
      ck = 8'h00;
      foreach (e[i]) ck ^= e[i];
      e = {e, ck, ~ck};
      k = 0;
      for (int t = 0; t < 400 && k < e.size(); t++) begin
         @(posedge ref_clk);
         if (host_tx_valid === 1'b1 && host_tx_ready) begin
            `CHK("response byte", e[k], host_tx_data)
            k++;
         end
         // Stall only while bytes remain, so ready ends high with one assignment per edge
         host_tx_ready <= (stall && k < e.size() && t < 399) ? ~host_tx_ready : 1'b1;
      end
      `CHK("response length", e.size(), k)
      repeat (2) @(posedge ref_clk);
      `CHK("busy after response", 1'b0, busy)
   endtask
   task automatic chk_fwd(input tba_q8 b);
      `CHK("forwarded count", b.size(), tag.cmd_q.size())
      foreach (b[i]) `CHK("forwarded byte", b[i], tag.cmd_q[i])
   endtask
   //////////////////////////////////////////
   task automatic t_read_single;
      n_rep <= 8'h05;
      send(mk(8'h00, 8'h20, 1), 1'b0);
      expect_rsp(8'h00, '{8'h00, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4}, 1'b0);
      chk_fwd(mk(8'h00, 8'h20, 1));
   endtask
   // Failing write with slow tag and stalling host: only flags and code return
   task automatic t_write_fail;
      slow <= 1'b1;
      fail <= 1'b1;
      n_rep <= 8'h03;
      send(mk(8'h00, 8'h21, 5), 1'b0);
      expect_rsp(8'h00, '{8'h01, 8'hB0}, 1'b1);
      chk_fwd(mk(8'h00, 8'h21, 5));
      slow <= 1'b0;
      fail <= 1'b0;
   endtask
   // Lock, multiple read and family write, back to back
   task automatic t_codes;
      logic [7:0] cd[3] = '{8'h22, 8'h23, 8'h27};
      int ex[3] = '{1, 2, 1};
      int nr[3] = '{0, 9, 0};
      tba_q8 d;
      for (int j = 0; j < 3; j++) begin
         n_rep <= 8'(nr[j]);
         d = {8'h00};
         for (int i = 0; i < nr[j]; i++) d.push_back(8'hB0 + 8'(i));
         send(mk(8'h00, cd[j], ex[j]), 1'b0);
         expect_rsp(8'h00, d, 1'b0);
         chk_fwd(mk(8'h00, cd[j], ex[j]));
      end
   endtask
   // Unsupported code, reserved flag bit, silent tag
   task automatic t_reader_err;
      logic [7:0] fl[3] = '{8'h00, 8'h80, 8'h00};
      logic [7:0] cd[3] = '{8'h25, 8'h20, 8'h20};
      logic [7:0] ec[3] = '{8'h02, 8'h04, 8'h01};
      for (int j = 0; j < 3; j++) begin
         mute <= (j == 2);
         send(mk(fl[j], cd[j], 1), 1'b0);
         expect_rsp(8'h10, '{ec[j]}, 1'b0);
      end
      mute <= 1'b0;
   endtask
   task automatic t_bad_sum;
      logic seen;
      seen = 1'b0;
      send(mk(8'h00, 8'h20, 1), 1'b1);
      repeat (12) begin
         @(posedge ref_clk);
         seen |= (frame_drop === 1'b1);
      end
      `CHK("frame dropped", 1'b1, seen)
      `CHK("nothing forwarded", 0, tag.cmd_q.size())
   endtask
   //////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // Whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_read_single();
      t_write_fail();
      t_codes();
      t_reader_err();
      t_bad_sum();
      t_read_single();
      finish_test();
   end
endmodule
